// [pkg/uart_defs.vh]
`ifndef UART_DEFS_VH
`define UART_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_DATA      3'h0
`define IDX_IER       3'h1
`define IDX_IIR       3'h2
`define IDX_LCTL      3'h3
`define IDX_MCTL      3'h4
`define IDX_LSR       3'h5
`define IDX_MSR       3'h6
`define IDX_LAST      3'h6

// Reset values
`define DIV_RESET     16'h0002
`define LCTL_RESET    8'h00
`define IER_RESET     4'h0
`define FCTL_RESET    8'h00
`define MCTL_RESET    2'h0

// Field positions
`define LCTL_DLAB     7
`define LCTL_BREAK    6
`define LCTL_EPS      4
`define LCTL_PEN      3
`define LCTL_STB      2
`define IER_RX        0
`define IER_TX        1
`define IER_LS        2
`define IER_MS        3
`define FCTL_EN       0
`define FCTL_RXCLR    1
`define FCTL_TXCLR    2

// Interrupt cause codes
`define IIR_NONE      4'h1
`define IIR_LS        4'h6
`define IIR_RX        4'h4
`define IIR_TO        4'hC
`define IIR_TX        4'h2
`define IIR_MS        4'h0

// Timing counts in baud ticks, bits and characters; FIFO depth in entries
`define TICKS_PER_BIT 16
`define HALF_BIT      4'h7
`define LAST_TICK     4'hF
`define CHAR_BITS     10
`define TIMEOUT_CHARS 4
`define TIMEOUT_TICKS (`TIMEOUT_CHARS * `CHAR_BITS * `TICKS_PER_BIT)
`define FIFO_DEPTH    16

`endif

// [rtl/uart_irq_baud.v]
// Contract
// [R01] Transmit interrupt when nothing waits to send; own enable; cleared by data write.
// [R02] FIFO on: data-ready interrupt while receive count reaches trigger level.
// [R03] FIFO off: data-ready interrupt while single receive buffer holds a byte.
// [R04] Timeout when below trigger and no FIFO access for four character times.
// [R05] Timeout stays until receive FIFO is emptied.
// [R06] Data-ready and timeout share one enable bit.
// [R07] Line status interrupt on parity, framing, overrun or break.
// [R08] Reading line status immediately drops pending line status interrupt.
// [R09] FIFO mode: line status interrupt only when erroneous byte is at head. Code also raises it at once on overrun.
// [R10] Summary error flag stays while any erroneous byte is in FIFO.
// [R11] Modem interrupt on handshake input change; cleared by reading handshake status. Code flags ring indicator only on its trailing edge.
// [R12] Reset loads all registers with defaults and flushes both FIFOs.
// [R13] Software sets divisor, disables interrupts, programs control, clears status, enables.
// [R14] Enabling transmit interrupt while empty fires at once; first write clears.
// [R15] Receiver has no disable and always hunts for a start bit.
// [R16] Software reads line status before each receive byte until empty.
// [R17] Without interrupts software polls status; cause register is not usable.
// [R18] 16-bit down-counter to 0001h, then reload and one-cycle end pulse.
// [R19] Divisor resets to 0002h.
// [R20] Divisor 0001h is valid and ticks every clock.
// [R21] Writing either divisor byte reloads counter and restarts count.
// [R22] Divisor bytes reachable only while line control bit 7 is set.
// [R23] Each serial bit lasts 16 baud ticks.
// [R24] Bit rate is clock over sixteen times divisor.
`include "uart_defs.vh"

module uart_irq_baud (
  // Clock and reset
  input  wire        sys_clk_i,
  input  wire        sys_rst_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // Serial line and handshake
  input  wire        rxd_i,
  input  wire        cts_n_i,
  input  wire        dsr_n_i,
  input  wire        dcd_n_i,
  input  wire        ri_n_i,
  output reg         txd_o,
  output reg         rts_n_o,
  output reg         dtr_n_o,
  // Events
  output reg         irq_o,
  output reg         baud_tick_o
);

  localparam ST_IDLE = 3'h0;
  localparam ST_STRT = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_PAR  = 3'h3;
  localparam ST_STOP = 3'h4;
  localparam ST_STP2 = 3'h5;

  function addr_ok;
    input [11:0] a;
    begin
      addr_ok = (a[11:5] == 7'h00) && (a[1:0] == 2'h0) && (a[4:2] <= `IDX_LAST);
    end
  endfunction

  function [4:0] trig_count;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    trig_count = 5'd1;
        2'h1:    trig_count = 5'd4;
        2'h2:    trig_count = 5'd8;
        default: trig_count = 5'd14;
      endcase
    end
  endfunction

  // Control registers
  reg  [7:0]  lctl_q;
  reg  [3:0]  ier_q;
  reg  [7:0]  fctl_q;
  reg  [1:0]  mctl_q;
  reg  [15:0] div_q;
  reg  [15:0] cnt_q;

  // Bus decode
  wire        acc    = psel_i & penable_i & pready_o;
  wire        ok     = addr_ok(paddr_i);
  wire [2:0]  idx    = paddr_i[4:2];
  wire        dlab   = lctl_q[`LCTL_DLAB];
  wire        wr     = acc & pwrite_i & ok;
  wire        rd     = acc & ~pwrite_i & ok;
  wire        wr_thr = wr & (idx == `IDX_DATA) & ~dlab;
  wire        wr_dll = wr & (idx == `IDX_DATA) & dlab;   // [R22]
  wire        wr_dlh = wr & (idx == `IDX_IER) & dlab;    // [R22]
  wire        wr_ier = wr & (idx == `IDX_IER) & ~dlab;
  wire        wr_fct = wr & (idx == `IDX_IIR);
  wire        rd_rbr = rd & (idx == `IDX_DATA) & ~dlab;
  wire        rd_lsr = rd & (idx == `IDX_LSR);
  wire        rd_msr = rd & (idx == `IDX_MSR);
  wire        fifo_en = fctl_q[`FCTL_EN];
  wire [15:0] div_new = wr_dll ? {div_q[15:8], pwdata_i[7:0]} : {pwdata_i[7:0], div_q[7:0]};

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lctl_q <= `LCTL_RESET;  // [R12] [R22]
      ier_q  <= `IER_RESET;
      fctl_q <= `FCTL_RESET;
      mctl_q <= `MCTL_RESET;
      div_q  <= `DIV_RESET;   // [R19]
    end else begin
      if (wr & (idx == `IDX_LCTL))
        lctl_q <= pwdata_i[7:0];
      if (wr_ier)
        ier_q <= pwdata_i[3:0];
      if (wr_fct)
        fctl_q <= {pwdata_i[7:6], 3'h0, pwdata_i[2:0]};
      if (wr & (idx == `IDX_MCTL))
        mctl_q <= pwdata_i[1:0];
      if (wr_dll | wr_dlh)
        div_q <= div_new;
    end
  end

  // Baud down-counter
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      cnt_q       <= `DIV_RESET;
      baud_tick_o <= 1'b0;
    end else if (wr_dll | wr_dlh) begin
      cnt_q       <= div_new;  // [R21]
      baud_tick_o <= 1'b0;
    end else if (cnt_q == 16'h0001) begin
      cnt_q       <= div_q;    // [R18] [R20]
      baud_tick_o <= 1'b1;
    end else begin
      cnt_q       <= cnt_q - 16'h0001;  // [R18]
      baud_tick_o <= 1'b0;
    end
  end

  // Input synchronisers
  reg  [4:0] sync1_q;
  reg  [4:0] sync2_q;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      sync1_q <= 5'h1F;
      sync2_q <= 5'h1F;
    end else begin
      sync1_q <= {ri_n_i, dcd_n_i, dsr_n_i, cts_n_i, rxd_i};
      sync2_q <= sync1_q;
    end
  end
  wire       rx_s  = sync2_q[0];
  wire [3:0] mdm_s = ~sync2_q[4:1];

  // Transmit FIFO
  reg  [7:0] tx_mem [0:`FIFO_DEPTH-1];
  reg  [3:0] tx_wp_q;
  reg  [3:0] tx_rp_q;
  reg  [4:0] tx_cnt_q;
  reg  [2:0] tx_st_q;
  reg  [3:0] tx_tk_q;
  reg  [2:0] tx_bit_q;
  reg  [7:0] tx_sh_q;
  reg        tx_par_q;
  wire       tx_full = fifo_en ? (tx_cnt_q == 5'd16) : (tx_cnt_q != 5'd0);
  wire       tx_push = wr_thr & ~tx_full;
  wire       tx_pop  = (tx_st_q == ST_IDLE) & (tx_cnt_q != 5'd0);
  wire       tx_end  = baud_tick_o & (tx_tk_q == `LAST_TICK);  // [R23] [R24]

  always @(posedge sys_clk_i) begin
    if (sys_rst_i | (wr_fct & pwdata_i[`FCTL_TXCLR])) begin
      tx_wp_q  <= 4'h0;  // [R12]
      tx_rp_q  <= 4'h0;
      tx_cnt_q <= 5'd0;
    end else begin
      if (tx_push) begin
        tx_mem[tx_wp_q] <= pwdata_i[7:0];
        tx_wp_q         <= tx_wp_q + 4'h1;
      end
      if (tx_pop)
        tx_rp_q <= tx_rp_q + 4'h1;
      tx_cnt_q <= tx_cnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
    end
  end

  // Transmitter
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      tx_st_q  <= ST_IDLE;
      tx_tk_q  <= 4'h0;
      tx_bit_q <= 3'h0;
      tx_sh_q  <= 8'h00;
      tx_par_q <= 1'b0;
      txd_o    <= 1'b1;
    end else begin
      if (baud_tick_o)
        tx_tk_q <= tx_tk_q + 4'h1;
      case (tx_st_q)
        ST_IDLE: begin
          tx_tk_q <= 4'h0;
          if (tx_pop) begin
            tx_sh_q  <= tx_mem[tx_rp_q];
            tx_par_q <= ~lctl_q[`LCTL_EPS];
            tx_st_q  <= ST_STRT;
          end
        end
        ST_STRT: if (tx_end) begin  // [R23]
          tx_st_q  <= ST_DATA;
          tx_bit_q <= 3'h0;
        end
        ST_DATA: if (tx_end) begin
          tx_par_q <= tx_par_q ^ tx_sh_q[0];
          tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
          tx_bit_q <= tx_bit_q + 3'h1;
          if (tx_bit_q == 3'h7)
            tx_st_q <= lctl_q[`LCTL_PEN] ? ST_PAR : ST_STOP;
        end
        ST_PAR:  if (tx_end)
          tx_st_q <= ST_STOP;
        ST_STOP: if (tx_end)
          tx_st_q <= lctl_q[`LCTL_STB] ? ST_STP2 : ST_IDLE;
        ST_STP2: if (tx_end)
          tx_st_q <= ST_IDLE;
        default: tx_st_q <= ST_IDLE;
      endcase
      if (lctl_q[`LCTL_BREAK])
        txd_o <= 1'b0;
      else
        case (tx_st_q)
          ST_STRT: txd_o <= 1'b0;
          ST_DATA: txd_o <= tx_sh_q[0];
          ST_PAR:  txd_o <= tx_par_q;
          default: txd_o <= 1'b1;
        endcase
    end
  end

  // Receiver, always hunting for a start bit
  reg  [2:0]  rx_st_q;
  reg  [3:0]  rx_tk_q;
  reg  [2:0]  rx_bit_q;
  reg  [7:0]  rx_sh_q;
  reg         rx_par_q;
  reg         rx_pe_q;
  reg         rx_push_q;
  reg  [10:0] rx_word_q;
  wire        rx_smp = baud_tick_o & (rx_tk_q == `LAST_TICK);
  wire        rx_brk = (rx_sh_q == 8'h00) & ~rx_s & ~(lctl_q[`LCTL_PEN] & rx_par_q);

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      rx_st_q   <= ST_IDLE;
      rx_tk_q   <= 4'h0;
      rx_bit_q  <= 3'h0;
      rx_sh_q   <= 8'h00;
      rx_par_q  <= 1'b0;
      rx_pe_q   <= 1'b0;
      rx_push_q <= 1'b0;
      rx_word_q <= 11'h000;
    end else begin
      rx_push_q <= 1'b0;
      if (baud_tick_o)
        rx_tk_q <= rx_tk_q + 4'h1;
      case (rx_st_q)
        ST_IDLE: begin
          rx_tk_q <= 4'h0;
          if (~rx_s)
            rx_st_q <= ST_STRT;  // [R15]
        end
        ST_STRT: if (baud_tick_o & (rx_tk_q == `HALF_BIT)) begin
          rx_tk_q  <= 4'h0;
          rx_bit_q <= 3'h0;
          rx_par_q <= ~lctl_q[`LCTL_EPS];
          rx_st_q  <= rx_s ? ST_IDLE : ST_DATA;
        end
        ST_DATA: if (rx_smp) begin  // [R23]
          rx_sh_q  <= {rx_s, rx_sh_q[7:1]};
          rx_par_q <= rx_par_q ^ rx_s;
          rx_bit_q <= rx_bit_q + 3'h1;
          if (rx_bit_q == 3'h7)
            rx_st_q <= lctl_q[`LCTL_PEN] ? ST_PAR : ST_STOP;
        end
        ST_PAR:  if (rx_smp) begin
          rx_pe_q  <= rx_par_q ^ rx_s;
          rx_par_q <= rx_s;
          rx_st_q  <= ST_STOP;
        end
        ST_STOP: if (rx_smp) begin
          rx_word_q <= {rx_brk, ~rx_s, lctl_q[`LCTL_PEN] & rx_pe_q, rx_sh_q};  // [R07]
          rx_push_q <= 1'b1;
          rx_pe_q   <= 1'b0;
          rx_st_q   <= ST_IDLE;
        end
        default: rx_st_q <= ST_IDLE;
      endcase
    end
  end

  // Receive FIFO with error tags
  reg  [10:0] rx_mem [0:`FIFO_DEPTH-1];
  reg  [3:0]  rx_wp_q;
  reg  [3:0]  rx_rp_q;
  reg  [4:0]  rx_cnt_q;
  reg  [4:0]  err_cnt_q;
  reg         oe_q;
  reg         pop_q;
  reg         head_err_q;
  wire        rx_full  = fifo_en ? (rx_cnt_q == 5'd16) : (rx_cnt_q != 5'd0);
  wire        rx_push  = rx_push_q & ~rx_full;
  wire        rx_pop   = rd_rbr & (rx_cnt_q != 5'd0);
  wire        rx_clr   = wr_fct & pwdata_i[`FCTL_RXCLR];
  wire [10:0] rx_head  = rx_mem[rx_rp_q];
  wire        head_err = (rx_cnt_q != 5'd0) & (|rx_head[10:8]);
  wire        push_err = rx_push & (|rx_word_q[10:8]);
  wire        pop_err  = rx_pop & (|rx_head[10:8]);

  always @(posedge sys_clk_i) begin
    if (sys_rst_i | rx_clr) begin
      rx_wp_q   <= 4'h0;  // [R12]
      rx_rp_q   <= 4'h0;
      rx_cnt_q  <= 5'd0;
      err_cnt_q <= 5'd0;
    end else begin
      if (rx_push) begin
        rx_mem[rx_wp_q] <= rx_word_q;
        rx_wp_q         <= rx_wp_q + 4'h1;
      end
      if (rx_pop)
        rx_rp_q <= rx_rp_q + 4'h1;
      rx_cnt_q  <= rx_cnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
      err_cnt_q <= err_cnt_q + {4'h0, push_err} - {4'h0, pop_err};  // [R10]
    end
  end

  // Interrupt sources
  reg         ls_pend_q;
  reg         thr_int_q;
  reg         tx_empty_q;
  reg         to_q;
  reg  [9:0]  to_cnt_q;
  reg  [3:0]  mdm_q;
  reg  [3:0]  delta_q;
  wire        ovr_evt  = rx_push_q & rx_full;
  wire        head_evt = head_err & (~head_err_q | pop_q);
  wire        tx_empty = (tx_cnt_q == 5'd0);
  wire        below    = (rx_cnt_q != 5'd0) & (rx_cnt_q < trig_count(fctl_q[7:6]));
  wire [3:0]  mdm_evt  = {mdm_q[3] & ~mdm_s[3], mdm_q[2:0] ^ mdm_s[2:0]};
  wire        rx_rdy   = fifo_en ? (rx_cnt_q >= trig_count(fctl_q[7:6]))  // [R02]
                                 : (rx_cnt_q != 5'd0);                   // [R03]

  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      ls_pend_q  <= 1'b0;
      oe_q       <= 1'b0;
      pop_q      <= 1'b0;
      head_err_q <= 1'b0;
      thr_int_q  <= 1'b0;
      tx_empty_q <= 1'b1;
      to_q       <= 1'b0;
      to_cnt_q   <= 10'd0;
      mdm_q      <= 4'h0;
      delta_q    <= 4'h0;
    end else begin
      pop_q      <= rx_pop;
      head_err_q <= head_err;
      tx_empty_q <= tx_empty;
      mdm_q      <= mdm_s;
      if (ovr_evt | (fifo_en ? head_evt : (rx_push & |rx_word_q[10:8])))  // [R07] [R09]
        ls_pend_q <= 1'b1;
      else if (rd_lsr)
        ls_pend_q <= 1'b0;  // [R08]
      if (ovr_evt)
        oe_q <= 1'b1;
      else if (rd_lsr)
        oe_q <= 1'b0;
      if (tx_empty & ((~tx_empty_q) | (wr_ier & pwdata_i[`IER_TX])))  // [R01] [R14]
        thr_int_q <= 1'b1;
      else if (wr_thr)
        thr_int_q <= 1'b0;  // [R01] [R14]
      if (rx_push | rx_pop | ~below)
        to_cnt_q <= 10'd0;
      else if (baud_tick_o & (to_cnt_q != `TIMEOUT_TICKS))
        to_cnt_q <= to_cnt_q + 10'd1;
      if (fifo_en & below & (to_cnt_q == `TIMEOUT_TICKS))
        to_q <= 1'b1;  // [R04]
      else if (rx_cnt_q == 5'd0)
        to_q <= 1'b0;  // [R05]
      delta_q <= mdm_evt | (rd_msr ? 4'h0 : delta_q);  // [R11]
    end
  end

  wire int_ls = ier_q[`IER_LS] & ls_pend_q;
  wire int_rx = ier_q[`IER_RX] & rx_rdy;       // [R06]
  wire int_to = ier_q[`IER_RX] & to_q;         // [R06]
  wire int_tx = ier_q[`IER_TX] & thr_int_q;    // [R01]
  wire int_ms = ier_q[`IER_MS] & (|delta_q);   // [R11]

  reg  [3:0] cause;
  always @* begin
    if (int_ls)
      cause = `IIR_LS;
    else if (int_rx)
      cause = `IIR_RX;
    else if (int_to)
      cause = `IIR_TO;
    else if (int_tx)
      cause = `IIR_TX;
    else if (int_ms)
      cause = `IIR_MS;
    else
      cause = `IIR_NONE;
  end

  // Read data mux
  reg  [7:0] rdata;
  always @* begin
    case (idx)
      `IDX_DATA: rdata = dlab ? div_q[7:0] : rx_head[7:0];
      `IDX_IER:  rdata = dlab ? div_q[15:8] : {4'h0, ier_q};
      `IDX_IIR:  rdata = {fifo_en, fifo_en, 2'h0, cause};
      `IDX_LCTL: rdata = lctl_q;
      `IDX_MCTL: rdata = {6'h00, mctl_q};
      `IDX_LSR:  rdata = {err_cnt_q != 5'd0, tx_empty & (tx_st_q == ST_IDLE), tx_empty,
                          rx_head[10:8] & {3{rx_cnt_q != 5'd0}}, oe_q, rx_cnt_q != 5'd0};
      `IDX_MSR:  rdata = {mdm_s, delta_q};
      default:   rdata = 8'h00;
    endcase
  end

  // APB response and pins
  wire setup_acc = psel_i & penable_i & ~pready_o;
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
      irq_o     <= 1'b0;
      rts_n_o   <= 1'b1;
      dtr_n_o   <= 1'b1;
    end else begin
      pready_o  <= setup_acc;
      pslverr_o <= setup_acc & ~ok;
      if (setup_acc)
        prdata_o <= (ok & ~pwrite_i) ? {24'h000000, rdata} : 32'h00000000;
      irq_o   <= int_ls | int_rx | int_to | int_tx | int_ms;
      dtr_n_o <= ~mctl_q[0];
      rts_n_o <= ~mctl_q[1];
    end
  end

endmodule

// [test/serial_peer.sv]
module serial_peer (
  // Clock
  input  logic clk_i,
  // Line from the device
  input  logic txd_i,
  // Lines to the device
  output logic rxd_o,
  output logic cts_n_o,
  output logic dsr_n_o,
  output logic dcd_n_o,
  output logic ri_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Divisor 1: one bit is 16 clocks
  localparam int BIT_CLKS = 16;

  initial begin
    rxd_o = 1'b1;
    {ri_n_o, dcd_n_o, dsr_n_o, cts_n_o} = 4'hF;
  end

  // Frame bits go out first bit first, then the line idles high
  task automatic send(input logic [10:0] f, input int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk_i);
      rxd_o <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk_i);
    end
    @(posedge clk_i);
    rxd_o <= 1'b1;
  endtask

  // Handshake pins, order ri, dcd, dsr, cts
  task automatic set_pins(input logic [3:0] v);
    @(posedge clk_i);
    {ri_n_o, dcd_n_o, dsr_n_o, cts_n_o} <= v;
  endtask

  // Samples each data bit in its middle, first bit first
  task automatic recv(output logic [7:0] b);
    @(negedge txd_i);
    repeat (BIT_CLKS / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk_i);
      b[i] = txd_i;
    end
  endtask
endmodule

// [test/uart_irq_baud_props.sv]
module uart_irq_baud_chk (
  // Clock and reset
  input logic        sys_clk_i,
  input logic        sys_rst_i,
  // Register bus
  input logic        psel_i,
  input logic        penable_i,
  input logic        pwrite_i,
  input logic [11:0] paddr_i,
  input logic [31:0] pwdata_i,
  input logic [31:0] prdata_o,
  input logic        pready_o,
  input logic        pslverr_o,
  // Line and events
  input logic        cts_n_i,
  input logic        txd_o,
  input logic        irq_o,
  input logic        baud_tick_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        lc7_q;
  logic [15:0] div_q;
  logic [3:0]  ier_q;
  logic [16:0] gap_q;
  logic [4:0]  tc_q;
  wire         wr     = psel_i & penable_i & pready_o & pwrite_i;
  wire         wr_div = wr & lc7_q & (paddr_i == 12'h000 | paddr_i == 12'h004);

  // Shadow of divisor, enables and divisor access bit; tick and bit counters
  always @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      lc7_q <= 1'b0;
      div_q <= 16'h0002;
      ier_q <= 4'h0;
      gap_q <= 17'h0;
      tc_q  <= 5'h0;
    end else begin
      if (wr && paddr_i == 12'h00C) lc7_q <= pwdata_i[7];
      if (wr_div && paddr_i == 12'h000) div_q[7:0] <= pwdata_i[7:0];
      if (wr_div && paddr_i == 12'h004) div_q[15:8] <= pwdata_i[7:0];
      if (wr && !lc7_q && paddr_i == 12'h004) ier_q <= pwdata_i[3:0];
      gap_q <= wr_div ? 17'h0 : (baud_tick_o ? 17'h1 : gap_q + 17'h1);
      tc_q  <= $changed(txd_o) ? {4'h0, baud_tick_o}
                               : tc_q + {4'h0, baud_tick_o & (tc_q != 5'h1F)};
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);

  property p_reset_out;
    $fell(sys_rst_i) |-> !irq_o && txd_o && !baud_tick_o && !pready_o;
  endproperty
  property p_tick_gap;
    baud_tick_o |-> gap_q == {1'b0, div_q};
  endproperty
  property p_div_read;
    psel_i && penable_i && pready_o && !pwrite_i && lc7_q && paddr_i == 12'h000
      |-> prdata_o == {24'h0, div_q[7:0]};
  endproperty
  property p_modem_irq;
    ier_q[3] && $changed(cts_n_i) |-> ##[1:6] irq_o;
  endproperty
  property p_masked;
    ier_q == 4'h0 && $past(ier_q) == 4'h0 |-> !irq_o;
  endproperty
  property p_txd_bit;
    $rose(txd_o) |-> tc_q >= 5'd15;
  endproperty
  property p_ready_wait;
    $rose(penable_i) && psel_i |-> !pready_o ##1 pready_o;
  endproperty
  property p_unmapped;
    psel_i && penable_i && pready_o && paddr_i[11:5] != 7'h0 |-> pslverr_o;
  endproperty

  a_reset_out: assert property (p_reset_out) else $error("outputs not idle after reset");
  a_tick_gap: assert property (p_tick_gap) else $error("baud tick spacing off");
  a_div_read: assert property (p_div_read) else $error("divisor readback off");
  a_modem_irq: assert property (p_modem_irq) else $error("no modem interrupt");
  a_masked: assert property (p_masked) else $error("interrupt while disabled");
  a_txd_bit: assert property (p_txd_bit) else $error("serial bit too short");
  a_ready_wait: assert property (p_ready_wait) else $error("ready timing off");
  a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");

  c_div_one: cover property (baud_tick_o && div_q == 16'h0001);
  c_irq: cover property ($rose(irq_o));
  c_err: cover property (pslverr_o);
endmodule

bind uart_irq_baud uart_irq_baud_chk u_chk (
  .sys_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .prdata_o, .pready_o, .pslverr_o, .cts_n_i, .txd_o, .irq_o, .baud_tick_o
);

// [test/uart_irq_baud_tb_top.sv]
module uart_irq_baud_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o, pslverr_o, rxd_i, cts_n_i, dsr_n_i, dcd_n_i, ri_n_i;
  logic        txd_o, rts_n_o, dtr_n_o, irq_o, baud_tick_o;
  logic [31:0] rdata;
  logic        rerr;
  int          err_total = 0;
  int          tests_run = 0;

  always #2.5 sys_clk_i = ~sys_clk_i;

  uart_irq_baud uut (
    .sys_clk_i, .sys_rst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .rxd_i, .cts_n_i, .dsr_n_i, .dcd_n_i, .ri_n_i,
    .txd_o, .rts_n_o, .dtr_n_o, .irq_o, .baud_tick_o
  );
  serial_peer peer (
    .clk_i(sys_clk_i), .txd_i(txd_o), .rxd_o(rxd_i), .cts_n_o(cts_n_i),
    .dsr_n_o(dsr_n_i), .dcd_n_o(dcd_n_i), .ri_n_o(ri_n_i)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
      err_total++;
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rdata = prdata_o;
    rerr = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wait_irq(output int n);
    n = 0;
    while (irq_o !== 1'b1 && n < 2000) begin
      @(posedge sys_clk_i);
      n++;
    end
  endtask

  task automatic tick_gap(output int g);
    g = 0;
    do begin
      @(posedge sys_clk_i);
      g++;
    end while (baud_tick_o !== 1'b1 && g < 100);
    g = 0;
    do begin
      @(posedge sys_clk_i);
      g++;
    end while (baud_tick_o !== 1'b1 && g < 100);
  endtask

  task automatic t_regs;
    int g;
    chk(irq_o, 0);
    chk({rts_n_o, dtr_n_o}, 2'h3);
    tick_gap(g);
    chk(g, 2);
    apb(1, 12'h00C, 8'h80);
    apb(0, 12'h000, 8'h00);
    chk(rdata, 32'h02);
    apb(0, 12'h004, 8'h00);
    chk(rdata, 32'h00);
    apb(1, 12'h000, 8'h01);
    tick_gap(g);
    chk(g, 1);
    apb(1, 12'h00C, 8'h00);
    apb(0, 12'h008, 8'h00);
    chk(rdata, 32'h01);
    apb(0, 12'h01C, 8'h00);
    chk(rerr, 1);
    apb(0, 12'h020, 8'h00);
    chk(rerr, 1);
  endtask

  task automatic t_tx;
    logic [7:0] b0, b1;
    int n;
    apb(1, 12'h004, 8'h02);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 1);
    apb(0, 12'h008, 8'h00);
    chk(rdata, 32'h02);
    fork
      begin
        peer.recv(b0);
        peer.recv(b1);
      end
      begin
        apb(1, 12'h000, 8'hA5);
        apb(1, 12'h000, 8'h5A);
        repeat (3) @(posedge sys_clk_i);
        chk(irq_o, 0);
      end
    join
    chk(b0, 8'hA5);
    chk(b1, 8'h5A);
    wait_irq(n);
    chk(irq_o, 1);
    apb(1, 12'h004, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 0);
  endtask

  task automatic t_rx;
    int n;
    apb(1, 12'h004, 8'h01);
    peer.send({1'b1, 8'h3C, 1'b0}, 10);
    wait_irq(n);
    apb(0, 12'h008, 8'h00);
    chk(rdata, 32'h04);
    apb(0, 12'h014, 8'h00);
    chk(rdata & 32'h1, 32'h1);
    apb(0, 12'h000, 8'h00);
    chk(rdata, 32'h3C);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 0);
  endtask

  task automatic t_lsr;
    logic [31:0] m;
    int n;
    apb(1, 12'h004, 8'h04);
    for (int k = 0; k < 4; k++) begin
      case (k)
        0: peer.send({1'b0, 8'h55, 1'b0}, 10);
        1: peer.send(11'h000, 10);
        2: begin
          apb(1, 12'h00C, 8'h08);
          peer.send({2'b11, 8'h01, 1'b0}, 11);
          apb(1, 12'h00C, 8'h00);
        end
        default: begin
          peer.send({1'b1, 8'h11, 1'b0}, 10);
          peer.send({1'b1, 8'h22, 1'b0}, 10);
        end
      endcase
      m = (k == 0) ? 32'h08 : (k == 1) ? 32'h10 : (k == 2) ? 32'h04 : 32'h02;
      wait_irq(n);
      apb(0, 12'h008, 8'h00);
      chk(rdata, 32'h06);
      apb(0, 12'h014, 8'h00);
      chk(rdata & m, m);
      repeat (2) @(posedge sys_clk_i);
      chk(irq_o, 0);
      apb(0, 12'h000, 8'h00);
    end
  endtask

  task automatic t_modem;
    apb(1, 12'h004, 8'h08);
    peer.set_pins(4'hE);
    repeat (6) @(posedge sys_clk_i);
    chk(irq_o, 1);
    apb(0, 12'h008, 8'h00);
    chk(rdata, 32'h00);
    apb(0, 12'h018, 8'h00);
    chk(rdata & 32'h1, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 0);
    peer.set_pins(4'h6);
    repeat (8) @(posedge sys_clk_i);
    chk(irq_o, 0);
    peer.set_pins(4'hE);
    repeat (6) @(posedge sys_clk_i);
    chk(irq_o, 1);
    apb(0, 12'h018, 8'h00);
    chk(rdata & 32'h8, 32'h8);
    apb(1, 12'h004, 8'h00);
    peer.set_pins(4'hF);
  endtask

  task automatic t_timeout;
    int n;
    apb(1, 12'h008, 8'h41);
    apb(1, 12'h004, 8'h01);
    peer.send({1'b1, 8'hA1, 1'b0}, 10);
    peer.send({1'b1, 8'hA2, 1'b0}, 10);
    wait_irq(n);
    chk(n >= 600 && n <= 660, 1);
    apb(0, 12'h008, 8'h00);
    chk(rdata, 32'hCC);
    apb(0, 12'h000, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 1);
    apb(0, 12'h000, 8'h00);
    chk(rdata, 32'hA2);
    repeat (3) @(posedge sys_clk_i);
    chk(irq_o, 0);
    for (int i = 0; i < 4; i++) begin
      if (i == 3) chk(irq_o, 0);
      peer.send({1'b1, 8'hB0 + 8'(i), 1'b0}, 10);
    end
    wait_irq(n);
    apb(0, 12'h008, 8'h00);
    chk(rdata, 32'hC4);
    apb(0, 12'h000, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk(irq_o, 0);
  endtask

  task automatic print_verdict;
    if (err_total == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    t_regs();
    t_tx();
    t_rx();
    t_lsr();
    t_modem();
    t_timeout();
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    err_total++;
    print_verdict();
  end
endmodule
